// ===== design/brpsc_sync.sv
// Multi-flop synchroniser with asynchronous reset to a constant
`timescale 1ns/1ns
module brpsc_sync
  import brpsc_pkg::*;
#(
  parameter int         W      = 1,
  parameter int         STAGES = 2,
  parameter logic [W-1:0] RVAL = '0
) (
  input  wire logic         clk,    // Sampling clock
  input  wire logic         rst_n,  // Async reset, active low
  input  wire logic [W-1:0] d,      // Asynchronous input
  output logic      [W-1:0] q       // Synchronised output
);
  // ==========================================================
  // Elaboration checks
  if (STAGES < 2) begin : g_bad
    $error("brpsc_sync needs at least two stages");
  end

  // Stage chain; each flop is read only by the next stage, the last by q
  logic [STAGES-1:0][W-1:0] stage;

  // ==========================================================
  // Shift chain
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      stage <= {STAGES{RVAL}};
    end else begin
      stage <= {stage[STAGES-2:0], d};
    end
  end

  assign q = stage[STAGES-1];
endmodule // brpsc_sync

// ===== design/brpsc_top.sv
// Reset, secondary reset and power-state control of the bridge
// ==========================================================
// Overview of operation
// - D3hot with strap: secondary clocks held low
// - D1 or D2 writes are discarded
// - D3hot to D0: clocks on, reset, no bus reset
// - Wake events are never forwarded across
// - Primary reset floats buses, resets registers
// - Primary reset edges may be asynchronous
// - Refuse accesses until 16 clocks after reset
// - Bus reset held through primary reset
// - Reset bit holds bus reset until cleared
// - Bus reset floats secondary control and grants
// - Bus reset drives data, enables, parity low
// - Bus reset clears all transaction buffers
// - Bit-driven bus reset keeps registers accessible
// - Chip reset bit resets all, sets reset bit
// - Release waits for bit clear and mask load
// - Chip bit self-clears within 20 clocks
// - D3cold returns only via power-up reset
// - Clock-mask load takes 23 clocks
`timescale 1ns/1ns
module brpsc_top
  import brpsc_pkg::*;
#(
  parameter int AW = 8
) (
  input  wire logic          pclk,                  // Primary clock
  input  wire logic          presetn,               // Primary reset, low
  input  wire logic          psel,                  // APB select
  input  wire logic          penable,               // APB enable
  input  wire logic          pwrite,                // APB write
  input  wire logic [AW-1:0] paddr,                 // APB address
  input  wire logic [31:0]   pwdata,                // APB write data
  output logic      [31:0]   prdata,                // APB read data
  output logic               pready,                // APB ready
  output logic               pslverr,               // APB error
  input  wire logic          sec_reset_pin_n,       // Bus reset pin, low
  input  wire logic          power_state_clock_gate_strap, // Gate strap
  input  wire logic          clock_mask_serial_input,      // Mask data
  output logic               sec_bus_reset_n,       // Bus reset out, low
  output logic               primary_float,         // Float primary bus
  output logic               secondary_float,       // Float sec control
  output logic               addr_data_cbe_par_low, // Drive AD/CBE/PAR 0
  output logic               buffer_clear,          // Flush buffers pulse
  output logic [NCLK-1:0]    secondary_clock_outputs_en, // Clock enables
  output logic               mask_shift_ctl,        // 0 load, 1 shift
  output logic               mask_shift_oe          // Shift ctl enable
);
  // ==========================================================
  // Elaboration checks
  if (AW < 8) begin : g_bad_aw
    $error("brpsc_top address too narrow");
  end

  // ==========================================================
  // State record
  typedef struct packed {
    logic [1:0]      pstate;   // Power state field
    logic            sec_bit;  // Secondary reset control
    logic            chip_bit; // Chip reset control
    logic [15:0]     mask;     // Clock mask
    logic [4:0]      mcnt;     // Mask load counter
    logic            mdone;    // Mask load finished
    logic [4:0]      hold;     // Post-reset refuse count
    logic [4:0]      ccnt;     // Chip release count
    logic            pready;   // Bus ready
    logic            pslverr;  // Bus error
    logic [31:0]     prdata;   // Bus read data
    logic            srst_n;   // Bus reset out
    logic            pfloat;   // Primary float
    logic            sfloat;   // Secondary float
    logic            slow;     // Drive low enable
    logic            bclr;     // Buffer flush pulse
    logic            sact_d;   // Previous reset activity
    logic [NCLK-1:0] clk_en;   // Clock enables
    logic            shctl;    // Shift control
    logic            shoe;     // Shift control enable
  } brpsc_state_type;

  brpsc_state_type s;       // Registered state
  brpsc_state_type next_s;  // Next state

  // ==========================================================
  // Synchronisers
  logic       rst_ok;  // Released reset, synced
  logic [2:0] pins;    // Synced strap, mask, pin

  // Assertion is immediate, release waits two edges
  // Reset release sync
  brpsc_sync #(
    .W      (1),
    .STAGES (2),
    .RVAL   (1'b0)
  ) u_rst_sync (
    .clk   (pclk),
    .rst_n (presetn),
    .d     (1'b1),
    .q     (rst_ok)
  );

  // Pin inputs arrive from outside this domain
  brpsc_sync #(
    .W      (3),
    .STAGES (2),
    .RVAL   (PIN_RST)
  ) u_pin_sync (
    .clk   (pclk),
    .rst_n (presetn),
    .d     ({power_state_clock_gate_strap,
             clock_mask_serial_input,
             sec_reset_pin_n}),
    .q     (pins)
  );

  logic strap_s;   // Synced gate strap
  logic msk_s;     // Synced mask bit
  logic secpin_n;  // Synced bus reset pin
  assign strap_s  = pins[2];
  assign msk_s    = pins[1];
  assign secpin_n = pins[0];

  // ==========================================================
  // Ungated clock enables from the mask
  logic [NCLK-1:0] en_w;  // One per secondary clock
  genvar gi;
  for (gi = 0; gi < NCLK; gi++) begin : g_en
    if (gi < NSLOT) begin : g_slot
      // Present bit low means a card sits there
      assign en_w[gi] = ~(s.mask[2*gi] & s.mask[2*gi+1]);
    end else begin : g_dev
      assign en_w[gi] = ~s.mask[gi+NSLOT];
    end
  end

  // ==========================================================
  // Decode helpers
  logic setup;    // APB setup cycle
  logic access;   // APB completing access
  logic refuse;   // Accesses rejected now
  logic gate;     // Clocks must stop
  logic sec_act;  // Bus reset active anywhere
  logic [1:0] wps; // Written power state

  assign setup   = psel & ~penable;
  assign access  = psel & penable & s.pready;
  assign refuse  = (s.hold != 5'h00) | ~rst_ok |
                   (s.chip_bit & ~s.sec_bit);
  assign gate    = (s.pstate == PS_D3) & strap_s;
  assign sec_act = ~s.srst_n | ~secpin_n;
  assign wps     = pwdata[PS_LSB+1:PS_LSB];

  // ==========================================================
  // Next-state logic
  always_comb begin
    next_s         = s;
    next_s.pready  = 1'b0;
    next_s.pslverr = 1'b0;
    next_s.bclr    = 1'b0;

    // Post-reset refuse window
    if (!rst_ok) begin
      next_s.hold = HOLD_CLKS;
    end else if (s.hold != 5'h00) begin
      next_s.hold = s.hold - 5'h01;
    end
    next_s.pfloat = ~rst_ok;

    if (rst_ok && !s.mdone) begin
      next_s.shoe  = 1'b1;
      next_s.shctl = (s.mcnt != 5'h00);
      next_s.mcnt  = s.mcnt + 5'h01;
      if (s.mcnt >= MCAP_LO && s.mcnt < MCAP_LO + MBITS) begin
        // Earlier counts still see pre-load bits in the sync flops
        // Most significant bit arrives first
        next_s.mask = {s.mask[14:0], msk_s};
      end
      if (s.mcnt == MLOAD_CLKS - 5'h01) begin
        next_s.mdone = 1'b1;
        next_s.shoe  = 1'b0;
        next_s.shctl = 1'b0;
      end
    end

    next_s.srst_n = ~(s.sec_bit | ~s.mdone);

    next_s.sfloat = sec_act;
    next_s.slow   = sec_act;
    next_s.sact_d = sec_act;
    if (sec_act && !s.sact_d) begin
      next_s.bclr = 1'b1;
    end

    if (s.chip_bit && !s.sec_bit && s.mdone) begin
      if (s.ccnt == CHIP_CLKS - 5'h01) begin
        next_s.chip_bit = 1'b0;
        next_s.ccnt     = 5'h00;
      end else begin
        next_s.ccnt = s.ccnt + 5'h01;
      end
    end

    next_s.clk_en = gate ? '0 : en_w;

    // Setup phase: answer in the first access cycle
    if (setup) begin
      next_s.pready = 1'b1;
      next_s.prdata = 32'h0000_0000;
      if (refuse) begin
        next_s.pslverr = 1'b1;
      end else if (paddr[7:0] == CTRL_ADDR) begin
        next_s.prdata[PS_LSB+1:PS_LSB] = s.pstate;
        next_s.prdata[SEC_BIT]         = s.sec_bit;
        next_s.prdata[CHIP_BIT]        = s.chip_bit;
      end else if (paddr[7:0] == STATUS_ADDR) begin
        next_s.prdata[ST_MDONE]  = s.mdone;
        next_s.prdata[ST_SECACT] = sec_act;
        next_s.prdata[ST_GATED]  = gate;
        next_s.prdata[ST_READY]  = ~refuse;
      end else if (paddr[7:0] == MASK_ADDR) begin
        next_s.prdata[15:0] = s.mask;
      end else begin
        // Unmapped addresses answer with an error
        next_s.pslverr = 1'b1;
      end
    end

    // Access phase: writes land on the completing edge
    if (access && pwrite && !s.pslverr) begin
      if (paddr[7:0] == CTRL_ADDR) begin
        next_s.sec_bit = pwdata[SEC_BIT];
        if (pwdata[CHIP_BIT]) begin
          next_s.pstate   = PS_D0;
          next_s.sec_bit  = 1'b1;
          next_s.chip_bit = 1'b1;
          next_s.mask     = MASK_RST;
          next_s.mcnt     = 5'h00;
          next_s.mdone    = 1'b0;
          next_s.ccnt     = 5'h00;
          next_s.pfloat   = 1'b1;
          next_s.sfloat   = 1'b1;
          next_s.bclr     = 1'b1;
        end else if (s.pstate == PS_D3 && wps == PS_D0) begin
          next_s.pstate  = PS_D0;
          next_s.sec_bit = 1'b0;
          next_s.bclr    = 1'b1;
        end else if (wps != PS_D1 && wps != PS_D2) begin
          next_s.pstate = wps;
        end
        // D1 and D2 leave the field alone
      end else if (paddr[7:0] == MASK_ADDR) begin
        // Mask may be rewritten after the load
        next_s.mask = pwdata[15:0];
      end
    end
  end

  // ==========================================================
  // State register
  // Defaults loaded on primary reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s          <= '0;
      s.mask     <= MASK_RST;
      s.hold     <= HOLD_CLKS;
      s.pfloat   <= 1'b1;
      s.sfloat   <= 1'b1;
      s.slow     <= 1'b1;
      s.sact_d   <= 1'b1;
    end else begin
      s <= next_s;
    end
  end

  // ==========================================================
  // Outputs, all registered
  // No wake signal ports exist
  assign prdata                     = s.prdata;
  assign pready                     = s.pready;
  assign pslverr                    = s.pslverr;
  assign sec_bus_reset_n            = s.srst_n;
  assign primary_float              = s.pfloat;
  assign secondary_float            = s.sfloat;
  assign addr_data_cbe_par_low      = s.slow;
  assign buffer_clear               = s.bclr;
  assign secondary_clock_outputs_en = s.clk_en;
  assign mask_shift_ctl             = s.shctl;
  assign mask_shift_oe              = s.shoe;

  // ==========================================================
  // Checks
  a_refuse_early: assert property (@(posedge pclk) disable iff (!presetn)
    setup && s.hold != 5'h00 |=> pready && pslverr)
    else $error("access taken during refuse window");

  a_d12_discard: assert property (@(posedge pclk) disable iff (!presetn)
    access && pwrite && !pslverr && paddr[7:0] == CTRL_ADDR &&
    !pwdata[CHIP_BIT] && (wps == PS_D1 || wps == PS_D2)
    |=> $stable(s.pstate))
    else $error("D1 or D2 write changed power state");

  a_clk_gate: assert property (@(posedge pclk) disable iff (!presetn)
    gate |=> secondary_clock_outputs_en == '0)
    else $error("clocks running in gated D3hot");

  a_sec_bit_hold: assert property (@(posedge pclk) disable iff (!presetn)
    s.sec_bit |=> !sec_bus_reset_n)
    else $error("bus reset released with control bit set");

  a_mask_wait: assert property (@(posedge pclk) disable iff (!presetn)
    !s.mdone |=> !sec_bus_reset_n)
    else $error("bus reset released before mask load");

  a_sec_float: assert property (@(posedge pclk) disable iff (!presetn)
    !sec_bus_reset_n |=> secondary_float && addr_data_cbe_par_low)
    else $error("secondary not floated under bus reset");

  a_buf_flush: assert property (@(posedge pclk) disable iff (!presetn)
    $fell(sec_bus_reset_n) && !$past(sec_act) |=> buffer_clear)
    else $error("buffers not flushed on bus reset");

  a_chip_clear: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(s.chip_bit & ~s.sec_bit & s.mdone) |-> ##[1:20] !s.chip_bit)
    else $error("chip bit not cleared in time");

  a_d3_exit: assert property (@(posedge pclk) disable iff (!presetn)
    access && pwrite && !pslverr && paddr[7:0] == CTRL_ADDR &&
    !pwdata[CHIP_BIT] && s.pstate == PS_D3 && wps == PS_D0
    |=> s.pstate == PS_D0 && buffer_clear && s.srst_n == $past(s.srst_n))
    else $error("D3hot exit did not reset cleanly");

  a_chip_set: assert property (@(posedge pclk) disable iff (!presetn)
    access && pwrite && !pslverr && paddr[7:0] == CTRL_ADDR &&
    pwdata[CHIP_BIT] |=> s.sec_bit && s.chip_bit ##1 !sec_bus_reset_n)
    else $error("chip reset did not set reset bit");

  a_mask_len: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(s.mdone) |-> $past(s.mcnt) == MLOAD_CLKS - 5'h01)
    else $error("mask load length wrong");
endmodule // brpsc_top

// ===== pkg/brpsc_pkg.sv
// Constants for the bridge reset and power-state controller
package brpsc_pkg;
  // ==========================================================
  // Register map (byte addresses)
  localparam logic [7:0] CTRL_ADDR   = 8'h00;
  localparam logic [7:0] STATUS_ADDR = 8'h04;
  localparam logic [7:0] MASK_ADDR   = 8'h08;
  // ==========================================================
  // Control register fields
  localparam int PS_LSB      = 0;
  localparam int SEC_BIT     = 2;
  localparam int CHIP_BIT    = 3;
  // Status register fields
  localparam int ST_MDONE    = 0;
  localparam int ST_SECACT   = 1;
  localparam int ST_GATED    = 2;
  localparam int ST_READY    = 3;
  // ==========================================================
  // Power state codes
  localparam logic [1:0] PS_D0 = 2'h0;
  localparam logic [1:0] PS_D1 = 2'h1;
  localparam logic [1:0] PS_D2 = 2'h2;
  localparam logic [1:0] PS_D3 = 2'h3;
  // ==========================================================
  // Timing counts in primary clocks
  localparam logic [4:0] HOLD_CLKS  = 5'h10;
  localparam logic [4:0] CHIP_CLKS  = 5'h14;
  localparam logic [4:0] MLOAD_CLKS = 5'h17;
  localparam logic [4:0] MBITS      = 5'h10;
  // First capture count: one drive cycle, one load cycle and two sync flops of lag
  localparam logic [4:0] MCAP_LO    = 5'h04;
  // ==========================================================
  // Reset values and clock counts
  localparam logic [15:0] MASK_RST  = 16'h0000;
  localparam logic [2:0]  PIN_RST   = 3'h1;
  localparam int          NCLK      = 10;
  localparam int          NSLOT     = 4;
endpackage : brpsc_pkg

// ===== verif/brpsc_mask_model.sv
// External clock-mask shift register feeding the serial mask input
`timescale 1ns/1ns
module brpsc_mask_model #(
  parameter logic [15:0] PATTERN = 16'h1f00  // Mask presented on load
) (
  input  wire logic pclk,                    // Primary clock
  input  wire logic mask_shift_ctl,          // 0 load, 1 shift
  input  wire logic mask_shift_oe,           // Control driven
  output logic      clock_mask_serial_input  // Serial mask bit
);
  // ==========================================================
  // Shift register
  logic [15:0] sr = 16'h5a5a;                // Shift stage
  always_ff @(posedge pclk) begin
    if (mask_shift_oe && !mask_shift_ctl) begin
      sr <= PATTERN;                         // Parallel load
    end else if (mask_shift_oe) begin
      sr <= {sr[14:0], 1'b0};                // Shift towards output
    end else begin
      // Undriven control: keep the line moving, never a stale level
      sr <= {sr[14:0], ~sr[15]};
    end
  end
  assign clock_mask_serial_input = sr[15];
endmodule // brpsc_mask_model

// ===== verif/testbench.sv
// Self-checking bench for the reset and power-state controller
`timescale 1ns/1ns
`define CHK(nm, exp, got) begin checks_done++; if ((got) !== (exp)) begin n_errors++; \
  $display("wrong value %s exp %h got %h", nm, exp, got); end end
module testbench;
  import brpsc_pkg::*;
  // ==========================================================
  // Signals
  localparam logic [15:0] PAT    = 16'h1f00;   // Mask from the model
  localparam logic [9:0]  EN_EXP = 10'h20f;    // Enables for PAT
  logic        pclk = 0, presetn = 0;          // Clock and reset
  logic        psel = 0, penable = 0, pwrite = 0; // APB control
  logic [7:0]  paddr = 8'h00;                  // APB address
  logic [31:0] pwdata = 32'h0, prdata, r;      // APB data
  logic        pready, pslverr, e;             // APB answer
  logic        sec_reset_pin_n = 1, strap = 0; // Pin inputs
  logic        serial, sec_n, pfl, sfl, low, bclr, sctl, soe; // Outputs
  logic [NCLK-1:0] clk_en;                     // Clock enables
  int          n_errors = 0, checks_done = 0, n_flush = 0, f, n; // Counters
  // ==========================================================
  // Design and shift register model
  always #50 pclk = ~pclk;
  brpsc_top u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .sec_reset_pin_n(sec_reset_pin_n), .power_state_clock_gate_strap(strap),
    .clock_mask_serial_input(serial), .sec_bus_reset_n(sec_n), .primary_float(pfl),
    .secondary_float(sfl), .addr_data_cbe_par_low(low), .buffer_clear(bclr),
    .secondary_clock_outputs_en(clk_en), .mask_shift_ctl(sctl), .mask_shift_oe(soe));
  brpsc_mask_model #(.PATTERN(PAT)) u_mask (.pclk(pclk), .mask_shift_ctl(sctl),
    .mask_shift_oe(soe), .clock_mask_serial_input(serial));
  // Flush pulses counted so short pulses are never missed
  always @(posedge pclk) if (bclr === 1'b1) n_flush++;
  // ==========================================================
  // Tasks
  task test_done;
    $display("checks %0d errors %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // One APB transfer; the answer is taken at the edge where pready is seen
  task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int i;
    @(posedge pclk);
    psel <= 1; penable <= 0; pwrite <= wr; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    for (i = 0; i < 20; i++) begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    r = prdata;
    e = pslverr;
    psel <= 0; penable <= 0;
    if (i == 20) begin n_errors++; test_done(); end
  endtask
  // Read with masked compare, refusal not expected
  task rd_chk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] x);
    apb(0, a, 0);
    `CHK("slverr", 1'b0, e)
    `CHK("read", x, r & m)
  endtask
  // Poll a status bit under a bound; long waits end the run
  task poll(input int b, input int lim);
    int k;
    for (k = 0; k < lim; k++) begin
      apb(0, STATUS_ADDR, 0);
      if (e === 1'b0 && r[b] === 1'b1) break;
    end
    if (k == lim) begin n_errors++; test_done(); end
  endtask
  task wait_rel;
    int k;
    for (k = 0; k < 100 && sec_n !== 1'b1; k++) @(posedge pclk);
    `CHK("sec release", 1'b1, sec_n)
    if (k == 100) test_done();
  endtask
  task bring_up;
    presetn <= 1;
    for (n = 0; n < 4; n++) begin apb(0, STATUS_ADDR, 0); `CHK("early", 1'b1, e) end
    poll(ST_READY, 40);
    poll(ST_MDONE, 60);
    wait_rel();
  endtask
  // ==========================================================
  // Main sequence
  initial begin
    repeat (3) @(posedge pclk);
    `CHK("rst sec", 1'b0, sec_n)
    `CHK("rst pfl", 1'b1, pfl)
    `CHK("rst sfl", 1'b1, sfl)
    `CHK("rst low", 1'b1, low)
    bring_up();
    rd_chk(MASK_ADDR, 32'hffff, {16'h0, PAT});
    `CHK("clk en", EN_EXP, clk_en)
    `CHK("pfl", 1'b0, pfl)
    $display("test reset done");
    // Unimplemented states are dropped
    for (n = 1; n < 3; n++) begin
      apb(1, CTRL_ADDR, n);
      rd_chk(CTRL_ADDR, 32'h3, 32'h0);
    end
    strap <= 1;
    apb(1, CTRL_ADDR, 3);
    repeat (5) @(posedge pclk);
    `CHK("gated", 10'h0, clk_en)
    rd_chk(STATUS_ADDR, 32'h4, 32'h4);
    f = n_flush;
    apb(1, CTRL_ADDR, 0);
    for (n = 0; n < 6; n++) begin @(posedge pclk); `CHK("no bus rst", 1'b1, sec_n) end
    `CHK("ungated", EN_EXP, clk_en)
    `CHK("flush d0", 1'b1, n_flush > f)
    strap <= 0;
    apb(1, CTRL_ADDR, 3);
    repeat (5) @(posedge pclk);
    `CHK("no strap", EN_EXP, clk_en)
    apb(1, CTRL_ADDR, 0);
    $display("test power done");
    // Secondary reset bit and pin
    f = n_flush;
    apb(1, CTRL_ADDR, 4);
    repeat (12) @(posedge pclk);
    `CHK("bit sec", 1'b0, sec_n)
    `CHK("bit sfl", 1'b1, sfl)
    `CHK("bit low", 1'b1, low)
    `CHK("bit flush", 1'b1, n_flush > f)
    rd_chk(STATUS_ADDR, 32'h2, 32'h2);
    rd_chk(CTRL_ADDR, 32'h4, 32'h4);
    apb(1, CTRL_ADDR, 0);
    repeat (4) @(posedge pclk);
    `CHK("bit clr", 1'b1, sec_n)
    sec_reset_pin_n <= 0;
    repeat (5) @(posedge pclk);
    `CHK("pin sfl", 1'b1, sfl)
    `CHK("pin low", 1'b1, low)
    sec_reset_pin_n <= 1;
    repeat (5) @(posedge pclk);
    apb(0, 8'h0c, 0);
    `CHK("unmapped", 1'b1, e)
    $display("test secondary done");
    // Chip reset through the diagnostic bit
    f = n_flush;
    apb(1, CTRL_ADDR, 8);
    repeat (2) @(posedge pclk);
    `CHK("chip sec", 1'b0, sec_n)
    `CHK("chip flush", 1'b1, n_flush > f)
    rd_chk(CTRL_ADDR, 32'hc, 32'hc);
    poll(ST_MDONE, 60);
    `CHK("chip hold", 1'b0, sec_n)
    apb(1, CTRL_ADDR, 0);
    apb(0, STATUS_ADDR, 0);
    `CHK("chip refuse", 1'b1, e)
    // Setup lands 21 edges after the releasing write: the 20-clock bound
    repeat (16) @(posedge pclk);
    rd_chk(CTRL_ADDR, 32'h8, 32'h0);
    wait_rel();
    rd_chk(MASK_ADDR, 32'hffff, {16'h0, PAT});
    $display("test chip done");
    // Second primary reset in mid-run
    apb(1, CTRL_ADDR, 4);
    presetn <= 0;
    repeat (2) @(posedge pclk);
    `CHK("prst pfl", 1'b1, pfl)
    `CHK("prst sec", 1'b0, sec_n)
    bring_up();
    rd_chk(CTRL_ADDR, 32'hf, 32'h0);
    $display("test second reset done");
    test_done();
  end
endmodule // testbench
